// file: core/iss_pkg.sv
// Package of constants and types for the interrupt source selector
package iss_pkg;

	localparam int SEL_W      = 5;
	localparam int NUM_SRC    = 32;
	localparam int NUM_LINES  = 12;
	localparam int FIRST_LINE = 4;
	localparam int CPU_IRQS   = 16;
	localparam int ADDR_W     = 32;
	localparam int DATA_W     = 32;
	localparam int FIELDS_PER_REG = 6;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] ADDR_SEL_UPPER = 32'h019C0000;
	localparam logic [ADDR_W-1:0] ADDR_SEL_LOWER = 32'h019C0004;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = 32'h019C0008;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK  = 32'h019C000C;

	// Field base bits inside a selector register; bits 15 and 31 unused
	localparam int FIELD_LSB [FIELDS_PER_REG] = '{0, 5, 10, 16, 21, 26};
	localparam logic [DATA_W-1:0] SEL_VALID_MASK = 32'h7FFF7FFF;

	// Reset source codes per maskable line, index 0 is CPU interrupt 4
	localparam logic [SEL_W-1:0] SEL_RESET [NUM_LINES] = '{
		5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
		5'h03, 5'h0A, 5'h0B, 5'h00, 5'h01, 5'h02};

	// Reserved codes which software must not write
	localparam logic [SEL_W-1:0] SEL_RSVD_A  = 5'h15;
	localparam logic [SEL_W-1:0] SEL_RSVD_B  = 5'h16;
	localparam logic [SEL_W-1:0] SEL_RSVD_LO = 5'h18;
	localparam logic [SEL_W-1:0] SEL_RSVD_HI = 5'h1D;

	// Fixed lines
	localparam int IRQ_RESET = 0;
	localparam int IRQ_NMI   = 1;

	// Status bits of the selector's own interrupt register
	localparam int STAT_W       = 1;
	localparam int STAT_RSVD_WR = 0;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} iss_bus_req_t;

	typedef struct packed {
		logic [DATA_W-1:0]                 selUpper;
		logic [DATA_W-1:0]                 selLower;
		logic [STAT_W-1:0]                 stat;
		logic [STAT_W-1:0]                 mask;
		logic [DATA_W-1:0]                 rdata;
		logic [NUM_LINES-1:0]              lines;
		logic [$clog2(CPU_IRQS)-1:0]       topIdx;
		logic                              topValid;
	} iss_state_t;

endpackage

// file: core/iss_selector.sv
// Interrupt source selector routing peripheral events onto CPU interrupt lines
//
// The register addresses and the strobed register port were chosen for this implementation.

module iss_selector (
	// Clock and reset
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	// Register port
	input  wire logic [iss_pkg::ADDR_W-1:0]        regAddr,
	input  wire logic [iss_pkg::DATA_W-1:0]        regWdata,
	input  wire logic                              regWr,
	input  wire logic                              regRd,
	output logic      [iss_pkg::DATA_W-1:0]        regRdata,
	// Event sources, indexed by selector code
	input  wire logic [iss_pkg::NUM_SRC-1:0]       srcEvent,
	// External interrupt pins 7:4, asynchronous
	input  wire logic [3:0]                        externalIrqPin,
	// Fixed inputs
	input  wire logic                              nmiIn,
	// CPU interrupt lines
	output logic      [iss_pkg::CPU_IRQS-1:0]      cpuIrq,
	output logic      [$clog2(iss_pkg::CPU_IRQS)-1:0] topIrqIdx,
	output logic                                   topIrqValid,
	// Own interrupt
	output logic                                   selIrq
);

	iss_pkg::iss_state_t s_q;
	iss_pkg::iss_state_t s_d;
	logic [3:0]                    pinMeta_q;
	logic [3:0]                    pinSync_q;
	logic [iss_pkg::NUM_SRC-1:0]   srcEff;
	logic [iss_pkg::CPU_IRQS-1:0]  allIrq;
	logic                          rsvdWrite;

	function automatic logic [iss_pkg::SEL_W-1:0] fieldOf(input logic [iss_pkg::DATA_W-1:0] r,
		input int k);
		fieldOf = r[iss_pkg::FIELD_LSB[k] +: iss_pkg::SEL_W];
	endfunction

	function automatic logic isReserved(input logic [iss_pkg::SEL_W-1:0] c);
		isReserved = (c == iss_pkg::SEL_RSVD_A) || (c == iss_pkg::SEL_RSVD_B) ||
			((c >= iss_pkg::SEL_RSVD_LO) && (c <= iss_pkg::SEL_RSVD_HI));
	endfunction

	// Pins come from outside the clock domain
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pinMeta_q <= 4'h0;
			pinSync_q <= 4'h0;
		end else begin
			pinMeta_q <= externalIrqPin;
			pinSync_q <= pinMeta_q;
		end
	end

	// Pins 7:4 merged with GPIO events 7:4 so they act as interrupts from reset
	always_comb begin
		srcEff = srcEvent;
		srcEff[7:4] = srcEvent[7:4] | pinSync_q;
	end

	// Reserved-code write is a software slip; flagged, not blocked
	always_comb begin
		rsvdWrite = 1'b0;
		if (regWr && ((regAddr == iss_pkg::ADDR_SEL_UPPER) ||
			(regAddr == iss_pkg::ADDR_SEL_LOWER))) begin
			for (int k = 0; k < iss_pkg::FIELDS_PER_REG; k++) begin
				if (isReserved(fieldOf(regWdata, k)))
					rsvdWrite = 1'b1;
			end
		end
	end

	always_comb begin
		s_d = s_q;
		s_d.rdata = '0;
		// Register writes
		if (regWr) begin
			unique case (regAddr)
				iss_pkg::ADDR_SEL_UPPER: s_d.selUpper = regWdata & iss_pkg::SEL_VALID_MASK;
				iss_pkg::ADDR_SEL_LOWER: s_d.selLower = regWdata & iss_pkg::SEL_VALID_MASK;
				iss_pkg::ADDR_IRQ_MASK:  s_d.mask = regWdata[iss_pkg::STAT_W-1:0];
				iss_pkg::ADDR_IRQ_STAT:  s_d.stat = s_q.stat & ~regWdata[iss_pkg::STAT_W-1:0];
				default: ;
			endcase
		end
		// Set wins over a write-one clear in the same cycle
		if (rsvdWrite)
			s_d.stat[iss_pkg::STAT_RSVD_WR] = 1'b1;
		// Reads, data valid the cycle after the strobe
		if (regRd) begin
			unique case (regAddr)
				iss_pkg::ADDR_SEL_UPPER: s_d.rdata = s_q.selUpper;
				iss_pkg::ADDR_SEL_LOWER: s_d.rdata = s_q.selLower;
				iss_pkg::ADDR_IRQ_STAT:  s_d.rdata = {{(iss_pkg::DATA_W-iss_pkg::STAT_W){1'b0}}, s_q.stat};
				iss_pkg::ADDR_IRQ_MASK:  s_d.rdata = {{(iss_pkg::DATA_W-iss_pkg::STAT_W){1'b0}}, s_q.mask};
				default:                 s_d.rdata = '0;
			endcase
		end
		// One register stage from source to line, using the current field
		for (int i = 0; i < iss_pkg::NUM_LINES; i++) begin
			if (i < iss_pkg::FIELDS_PER_REG)
				s_d.lines[i] = srcEff[fieldOf(s_q.selLower, i)];
			else
				s_d.lines[i] = srcEff[fieldOf(s_q.selUpper, i - iss_pkg::FIELDS_PER_REG)];
		end
		// Lowest pending by number, 0 first
		s_d.topValid = 1'b0;
		s_d.topIdx = '0;
		for (int j = iss_pkg::CPU_IRQS - 1; j >= 0; j--) begin
			if (allIrq[j]) begin
				s_d.topValid = 1'b1;
				s_d.topIdx = 4'(j);
			end
		end
	end

	// Reset values packed from the per-line table
	function automatic logic [iss_pkg::DATA_W-1:0] resetReg(input int base);
		logic [iss_pkg::DATA_W-1:0] r;
		r = '0;
		for (int k = 0; k < iss_pkg::FIELDS_PER_REG; k++)
			r[iss_pkg::FIELD_LSB[k] +: iss_pkg::SEL_W] = iss_pkg::SEL_RESET[base + k];
		resetReg = r;
	endfunction

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q          <= '0;
			s_q.selLower <= resetReg(0);
			s_q.selUpper <= resetReg(iss_pkg::FIELDS_PER_REG);
		end else begin
			s_q <= s_d;
		end
	end

	// Lines 0-3 never pass the selector; reset drives line 0, line 2-3 unused
	always_comb begin
		allIrq = '0;
		allIrq[iss_pkg::IRQ_RESET] = ~rst_n;
		allIrq[iss_pkg::IRQ_NMI] = nmiIn;
		allIrq[iss_pkg::CPU_IRQS-1:iss_pkg::FIRST_LINE] = s_q.lines;
	end

	assign cpuIrq      = allIrq;
	assign regRdata    = s_q.rdata;
	assign topIrqIdx   = s_q.topIdx;
	assign topIrqValid = s_q.topValid;
	assign selIrq      = |(s_q.stat & s_q.mask);

	property p_route_lower;
		@(posedge clk) disable iff (!rst_n)
		srcEff[s_q.selLower[4:0]] |=> s_q.lines[0];
	endproperty
	a_route_lower: assert property (p_route_lower) else $error("line 4 missed source");

	property p_route_upper;
		@(posedge clk) disable iff (!rst_n)
		!srcEff[s_q.selUpper[30:26]] |=> !s_q.lines[11];
	endproperty
	a_route_upper: assert property (p_route_upper) else $error("line 15 wrong");

	property p_gap_bits;
		@(posedge clk) disable iff (!rst_n)
		(s_q.selLower[15] == 1'b0) && (s_q.selLower[31] == 1'b0) &&
		(s_q.selUpper[15] == 1'b0) && (s_q.selUpper[31] == 1'b0);
	endproperty
	a_gap_bits: assert property (p_gap_bits) else $error("gap bit set");

	property p_reset_lower;
		@(posedge clk) $rose(rst_n) |-> s_q.selLower == 32'h250718A4;
	endproperty
	a_reset_lower: assert property (p_reset_lower) else $error("lower reset wrong");

	property p_reset_upper;
		@(posedge clk) $rose(rst_n) |-> (s_q.selUpper[4:0] == 5'h03) &&
			(s_q.selUpper[9:5] == 5'h0A) && (s_q.selUpper[30:26] == 5'h02);
	endproperty
	a_reset_upper: assert property (p_reset_upper) else $error("upper reset wrong");

	property p_rd_upper;
		@(posedge clk) disable iff (!rst_n)
		regRd && (regAddr == iss_pkg::ADDR_SEL_UPPER) && !regWr |=>
			regRdata == $past(s_q.selUpper);
	endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper readback wrong");

	property p_pin_route;
		@(posedge clk) disable iff (!rst_n)
		externalIrqPin[0] [*3] ##0 (s_q.selLower[4:0] == 5'h04) [*2] |=> s_q.lines[0];
	endproperty
	a_pin_route: assert property (p_pin_route) else $error("pin 4 not routed");

	property p_priority;
		@(posedge clk) disable iff (!rst_n)
		nmiIn |=> topIrqValid && (topIrqIdx <= 4'h1);
	endproperty
	a_priority: assert property (p_priority) else $error("priority wrong");

	property p_fixed;
		@(posedge clk) disable iff (!rst_n)
		cpuIrq[1] == nmiIn && !cpuIrq[2] && !cpuIrq[3];
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed lines disturbed");

	property p_rsvd_flag;
		@(posedge clk) disable iff (!rst_n)
		rsvdWrite |=> s_q.stat[iss_pkg::STAT_RSVD_WR];
	endproperty
	a_rsvd_flag: assert property (p_rsvd_flag) else $error("reserved write not flagged");

	// Read data must not linger, or a stale word would look like a fresh read
	property p_rdata_idle;
		@(posedge clk) disable iff (!rst_n)
		!$past(regRd) |-> regRdata == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

	property p_reset_line;
		@(posedge clk)
		cpuIrq[iss_pkg::IRQ_RESET] == !rst_n;
	endproperty
	a_reset_line: assert property (p_reset_line) else $error("reset line wrong");

	property p_route_line13;
		@(posedge clk) disable iff (!rst_n)
		srcEff[s_q.selUpper[20:16]] |=> s_q.lines[9];
	endproperty
	a_route_line13: assert property (p_route_line13) else $error("line 13 missed source");

	property p_write_lower;
		@(posedge clk) disable iff (!rst_n)
		regWr && (regAddr == iss_pkg::ADDR_SEL_LOWER) |=>
			s_q.selLower == ($past(regWdata) & iss_pkg::SEL_VALID_MASK);
	endproperty
	a_write_lower: assert property (p_write_lower) else $error("lower write wrong");

endmodule

// file: testbench/interrupt_source_selector_tb_top.sv
// Self-checking bench for the interrupt source selector
module interrupt_source_selector_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, regWr, regRd, nmiIn, fire, topIrqValid, selIrq;
	logic [31:0] regAddr, regWdata, regRdata, evMask, srcEvent;
	logic [3:0]  externalIrqPin, topIrqIdx;
	logic [15:0] cpuIrq;
	int          n_mismatch, num_checks;
	int          sel [12];
	int          lsb [6] = '{0, 5, 10, 16, 21, 26};

	iss_event_source i_src (.clk(clk), .fire(fire), .evMask(evMask), .srcEvent(srcEvent));
	iss_selector i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .srcEvent(srcEvent),
		.externalIrqPin(externalIrqPin), .nmiIn(nmiIn), .cpuIrq(cpuIrq),
		.topIrqIdx(topIrqIdx), .topIrqValid(topIrqValid), .selIrq(selIrq));

	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function automatic logic [31:0] word(int u);
		logic [31:0] w;
		w = 32'h00000000;
		for (int j = 0; j < 6; j++)
			w |= 32'(sel[u*6+j]) << lsb[j];
		return w;
	endfunction

	function automatic bit rsvd(int c);
		return c == 21 || c == 22 || (c >= 24 && c <= 29);
	endfunction

	task automatic wr(logic [31:0] a, logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'h1;
		@(posedge clk);
		regWr <= 1'h0;
	endtask

	task automatic rd(logic [31:0] a, output logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge clk);
		regRd <= 1'h0;
		#1 d = regRdata;
	endtask

	task automatic chkRegs;
		logic [31:0] d;
		for (int u = 0; u < 2; u++) begin
			rd(u ? 32'h019C0000 : 32'h019C0004, d);
			chk("selector word", word(u), d);
		end
	endtask

	// Spare bits 15 and 31 are written as ones; they must not stick
	task automatic setSel(int i, int c);
		sel[i] = c;
		wr(i >= 6 ? 32'h019C0000 : 32'h019C0004, word(i >= 6) | 32'h80008000);
	endtask

	task automatic fireCheck(logic [31:0] m);
		logic [15:0] e;
		int t;
		// Expected lines taken after the edge, so a just-scheduled nmiIn is seen
		@(posedge clk);
		e = {14'h0000, nmiIn, 1'h0};
		for (int i = 0; i < 12; i++)
			if (m[sel[i]]) e[4+i] = 1'h1;
		t = 0;
		for (int k = 15; k >= 0; k--)
			if (e[k]) t = k;
		fire <= 1'h1;
		evMask <= m;
		@(posedge clk);
		fire <= 1'h0;
		@(posedge clk);
		#1 chk("cpu lines", 32'(e), 32'(cpuIrq));
		@(posedge clk);
		#1 chk("top valid", 32'(e != 0), 32'(topIrqValid));
		if (e != 0)
			chk("top index", 32'(t), 32'(topIrqIdx));
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		tally_and_finish;
	end

	initial begin
		logic [31:0] d;
		int c;
		{rst_n, regWr, regRd, nmiIn, fire} = 5'h00;
		{regAddr, regWdata, evMask} = 96'h0;
		externalIrqPin = 4'h0;
		void'($urandom(25));
		sel = '{4, 5, 6, 7, 8, 9, 3, 10, 11, 0, 1, 2};
		@(posedge clk);
		#1 chk("reset lines", 32'h00000001, 32'(cpuIrq));
		@(posedge clk);
		rst_n <= 1'h1;
		chkRegs;
		rd(32'h019C0010, d);
		chk("unmapped", 32'h00000000, d);
		for (int i = 0; i < 12; i++)
			fireCheck(32'h1 << sel[i]);
		fireCheck(32'h00000048);
		nmiIn <= 1'h1;
		fireCheck(32'h00000004);
		nmiIn <= 1'h0;
		$display("test defaults done");
		@(posedge clk);
		externalIrqPin <= 4'h8;
		repeat (3) @(posedge clk);
		#1 chk("pin line", 32'h1, 32'(cpuIrq[7]));
		externalIrqPin <= 4'h0;
		repeat (4) @(posedge clk);
		$display("test pins done");
		for (int n = 0; n < 12; n++) begin
			do c = $urandom % 32; while (rsvd(c));
			setSel(n, c);
		end
		chkRegs;
		// Every legal code on one line, with the other lines random
		for (c = 0; c < 32; c++)
			if (!rsvd(c)) begin
				setSel(0, c);
				fireCheck(32'h1 << c);
			end
		$display("test codes done");
		wr(32'h019C000C, 32'h1);
		setSel(3, 21);
		rd(32'h019C0008, d);
		chk("status", 32'h1, d);
		chk("sel irq", 32'h1, 32'(selIrq));
		wr(32'h019C0008, 32'h1);
		wr(32'h019C000C, 32'h0);
		rd(32'h019C0008, d);
		chk("status clear", 32'h0, d);
		setSel(3, 22);
		rd(32'h019C0008, d);
		chk("status again", 32'h1, d);
		chk("masked irq", 32'h0, 32'(selIrq));
		$display("test irq done");
		tally_and_finish;
	end
endmodule

// file: testbench/iss_event_source.sv
// Peripheral event sources feeding the selector
module iss_event_source (
	// Clock
	input  wire logic        clk,
	// Request from the bench
	input  wire logic        fire,
	input  wire logic [31:0] evMask,
	// Event lines
	output logic      [31:0] srcEvent
);
	timeunit 1ns;
	timeprecision 1ps;
	// One-cycle strobes, as peripherals raise them; low otherwise
	always_ff @(posedge clk) begin
		srcEvent <= fire ? evMask : 32'h00000000;
	end
endmodule
